// ==== rtl/cbr_pkg.sv ====
// constants, opcodes and types shared by the processor core and its bench.
// assumes a single 50 MHz clock and an active-low asynchronous reset.
package cbr_pkg;

  // vector locations
  localparam logic [15:0] RESET_VEC_LO  = 16'hfffc;
  localparam logic [15:0] RESET_VEC_HI  = 16'hfffd;
  localparam logic [15:0] IRQ_VEC_LO    = 16'hfffe;
  localparam logic [15:0] IRQ_VEC_HI    = 16'hffff;

  // on-chip port registers
  localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
  localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
  localparam logic [7:0]  PORT_DIR_RST  = 8'h00;
  localparam logic [7:0]  PORT_OUT_RST  = 8'h00;

  // stack and status
  localparam logic [7:0]  STACK_PAGE    = 8'h01;
  localparam logic [7:0]  SP_RST        = 8'hff;
  localparam logic [7:0]  STATUS_RST    = 8'h24;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_Z        = 1;
  localparam int          FLAG_I        = 2;
  localparam int          FLAG_N        = 7;

  // start-up delay in clock cycles after reset release
  localparam logic [2:0]  INIT_CYCLES   = 3'h6;

  // opcodes outside the regular load/store group
  localparam logic [7:0]  OP_LDX_IMM    = 8'ha2;
  localparam logic [7:0]  OP_LDY_IMM    = 8'ha0;
  localparam logic [7:0]  OP_TAX        = 8'haa;
  localparam logic [7:0]  OP_INX        = 8'he8;
  localparam logic [7:0]  OP_ASL_A      = 8'h0a;
  localparam logic [7:0]  OP_CLI        = 8'h58;
  localparam logic [7:0]  OP_SEI        = 8'h78;
  localparam logic [7:0]  OP_BNE        = 8'hd0;
  localparam logic [7:0]  OP_BEQ        = 8'hf0;
  localparam logic [7:0]  OP_JMP_ABS    = 8'h4c;
  localparam logic [7:0]  OP_RTI        = 8'h40;
  // load/store group: low two bits and operation field
  localparam logic [1:0]  GRP_LDST      = 2'h1;
  localparam logic [2:0]  OPF_STORE     = 3'h4;
  localparam logic [2:0]  OPF_LOAD      = 3'h5;

  // read data source of the previous bus cycle
  localparam logic [1:0]  SRC_EXT       = 2'h0;
  localparam logic [1:0]  SRC_RAM       = 2'h1;
  localparam logic [1:0]  SRC_PORT      = 2'h2;

  // sequencer states, one-hot
  typedef enum logic [15:0] {
    ST_INIT    = 16'h0001,
    ST_VEC_REQ = 16'h0002,
    ST_VEC_LO  = 16'h0004,
    ST_VEC_HI  = 16'h0008,
    ST_FETCH   = 16'h0010,
    ST_DECODE  = 16'h0020,
    ST_OP1     = 16'h0040,
    ST_OP2     = 16'h0080,
    ST_PTR_LO  = 16'h0100,
    ST_PTR_HI  = 16'h0200,
    ST_EXEC    = 16'h0400,
    ST_PUSH_L  = 16'h0800,
    ST_PUSH_P  = 16'h1000,
    ST_PULL_P  = 16'h2000,
    ST_PULL_L  = 16'h4000,
    ST_PULL_H  = 16'h8000
  } cbr_state_t;

  // addressing modes
  typedef enum logic [3:0] {
    AM_IMPL = 4'h0,
    AM_ACC  = 4'h1,
    AM_IMM  = 4'h2,
    AM_ZP   = 4'h3,
    AM_ZPX  = 4'h4,
    AM_ABS  = 4'h5,
    AM_ABSX = 4'h6,
    AM_ABSY = 4'h7,
    AM_INDX = 4'h8,
    AM_REL  = 4'h9
  } cbr_mode_t;

endpackage : cbr_pkg

// ==== rtl/cbr_ram.sv ====
// on-chip scratch ram with registered read data.
// assumes address and write strobe are presented a cycle before data is used.
module cbr_ram #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8,
  parameter int AW    = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // access port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];  // storage, not reset

  // write port; content is undefined until software writes it
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // read port, registered so a read lands in the next cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule : cbr_ram

// ==== rtl/cbr_core.sv ====
// processor control core: reset start-up, interrupt entry, bus direction,
// on-chip port and ram decode, and effective address formation.
// assumes external memory answers combinationally in the cycle after an address.
// Notes on behaviour
// - no bus writes while reset is low
// - reset release starts the start-up sequence
// - six cycles, set mask, load reset vector
// - write strobe valid from reset onward
// - interrupts taken only between instructions
// - accepted interrupt pushes counter and status
// - entry sets mask, loads interrupt vector
// - address drive follows address enable input
// - port latch at one, direction at zero
// - each port bit has its own direction
// - write strobe low only on writes
// - pages zero and one share one ram
// - data lines undriven on internal accesses
// - accumulator and implied: single byte opcodes
// - immediate operand is the second byte
// - absolute: second low, third high byte
// - zero page forces high byte zero
// - indexed zero page wraps within page zero
// - indexed absolute adds index to base
// - branches add signed offset to next counter
// - indexed indirect fetches pointer from page zero
module cbr_core
  import cbr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // bus ownership
  input  wire logic        address_drive_enable,
  // address lines
  output logic      [15:0] address_lines_o,
  output logic             address_lines_oe,
  // data lines
  input  wire logic [7:0]  data_lines_i,
  output logic      [7:0]  data_lines_o,
  output logic             data_lines_oe,
  // transfer direction, low while writing
  output logic             write_n,
  // interrupt request, active low
  input  wire logic        irq_n,
  // peripheral port
  input  wire logic [7:0]  peripheral_port_pins_i,
  output logic      [7:0]  peripheral_port_pins_o,
  output logic      [7:0]  peripheral_port_pins_oe
);
  import cbr_pkg::*;

  // sequencer and architectural state
  cbr_state_t  state_r, state_nxt;     // sequencer state
  logic [2:0]  cnt_r, cnt_nxt;         // start-up cycle counter
  logic [7:0]  a_r, a_nxt;             // accumulator
  logic [7:0]  x_r, x_nxt;             // first index
  logic [7:0]  y_r, y_nxt;             // second index
  logic [7:0]  sp_r, sp_nxt;           // stack pointer
  logic [15:0] pc_r, pc_nxt;           // program counter
  logic [7:0]  p_r, p_nxt;             // processor status
  logic [7:0]  ir_r, ir_nxt;           // current opcode
  logic [7:0]  b2_r, b2_nxt;           // second byte or pointer low
  logic [7:0]  ptr_r, ptr_nxt;         // page-zero pointer
  logic        vec_irq_r, vec_irq_nxt; // vector select: interrupt or reset
  // bus request for the next cycle
  logic [15:0] bus_a_nxt;              // next address
  logic        bus_we_nxt;             // next cycle writes
  logic [7:0]  bus_wd_nxt;             // next write data
  logic        acc_go;                 // operand access requested
  logic [15:0] acc_ea;                 // effective address of it
  // read path
  logic [1:0]  rd_src_r;               // source of the pending read
  logic [7:0]  port_rd_r;              // port value captured at issue
  logic [7:0]  ram_rdata;              // ram read data
  logic [7:0]  rdata;                  // data of the previous cycle
  logic [7:0]  port_dir_r;             // port direction register
  logic [7:0]  port_out_r;             // port output latch
  logic [7:0]  port_view;              // port value as software reads it
  // helper arithmetic
  logic [7:0]  zp_sum;                 // page-zero index sum, carry dropped
  logic [7:0]  inx_val;                // incremented first index
  logic [7:0]  shl_val;                // accumulator shifted left
  logic [15:0] rel_off;                // sign-extended branch offset
  logic [15:0] op2_base;               // absolute base address
  logic        bne_taken;              // branch condition met

  // pages zero and one both land in the ram
  function automatic logic is_internal(input logic [15:0] addr);
    return (addr[15:9] == 7'h00);
  endfunction : is_internal

  // the two port registers sit only at the very bottom of page zero
  function automatic logic is_port(input logic [15:0] addr);
    return (addr[15:1] == PORT_DIR_ADDR[15:1]);
  endfunction : is_port

  // the store form of the load/store group
  function automatic logic is_store(input logic [7:0] op);
    return (op[1:0] == GRP_LDST) && (op[7:5] == OPF_STORE);
  endfunction : is_store

  // addressing mode of an opcode; unknown opcodes act as single-byte no-ops
  function automatic cbr_mode_t mode_of(input logic [7:0] op);
    cbr_mode_t m;
    m = AM_IMPL;
    if (op[1:0] == GRP_LDST && (op[7:5] == OPF_LOAD || op[7:5] == OPF_STORE)) begin
      case (op[4:2])
        3'h0:    m = AM_INDX;
        3'h1:    m = AM_ZP;
        3'h2:    m = is_store(op) ? AM_IMPL : AM_IMM;
        3'h3:    m = AM_ABS;
        3'h5:    m = AM_ZPX;
        3'h6:    m = AM_ABSY;
        3'h7:    m = AM_ABSX;
        default: m = AM_IMPL;
      endcase
    end else begin
      case (op)
        OP_LDX_IMM, OP_LDY_IMM: m = AM_IMM;
        OP_BNE, OP_BEQ:         m = AM_REL;
        OP_JMP_ABS:             m = AM_ABS;
        OP_ASL_A:               m = AM_ACC;
        default:                m = AM_IMPL;
      endcase
    end
    return m;
  endfunction : mode_of

  // status with sign and zero taken from a result
  function automatic logic [7:0] with_nz(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    r = p;
    r[FLAG_N] = v[7];
    r[FLAG_Z] = (v == 8'h00);
    return r;
  endfunction : with_nz

  // helper arithmetic, all kept at operand width so carries drop
  // carry out of page-zero index discarded
  assign zp_sum    = rdata + x_r;
  assign inx_val   = x_r + 8'h01;
  assign shl_val   = {a_r[6:0], 1'b0};
  assign rel_off   = {{8{rdata[7]}}, rdata};
  assign op2_base  = {rdata, b2_r};
  assign bne_taken = (ir_r == OP_BEQ) == p_r[FLAG_Z];

  // read data of the previous cycle: ram and port answer internally
  // internal reads ignore the data lines
  assign rdata = (rd_src_r == SRC_RAM)  ? ram_rdata :
                 (rd_src_r == SRC_PORT) ? port_rd_r : data_lines_i;

  // per-bit choice of latch or pin
  for (genvar i = 0; i < 8; i++) begin : g_port_bit
    assign port_view[i] = port_dir_r[i] ? port_out_r[i] : peripheral_port_pins_i[i];
  end

  // port pins come straight from the two registers
  assign peripheral_port_pins_o  = port_out_r;
  assign peripheral_port_pins_oe = port_dir_r;

  // ram indexed by the low address byte only
  cbr_ram #(.DEPTH(256), .WIDTH(8), .AW(8)) u_ram (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr_en   (bus_we_nxt && is_internal(bus_a_nxt) && !is_port(bus_a_nxt)),
    .addr    (bus_a_nxt[7:0]),
    .wdata   (bus_wd_nxt),
    .rdata   (ram_rdata)
  );

  // sequencer: each state uses the data of the last cycle and requests the next
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    a_nxt       = a_r;
    x_nxt       = x_r;
    y_nxt       = y_r;
    sp_nxt      = sp_r;
    pc_nxt      = pc_r;
    p_nxt       = p_r;
    ir_nxt      = ir_r;
    b2_nxt      = b2_r;
    ptr_nxt     = ptr_r;
    vec_irq_nxt = vec_irq_r;
    bus_a_nxt   = address_lines_o;
    bus_we_nxt  = 1'b0;
    bus_wd_nxt  = data_lines_o;
    acc_go      = 1'b0;
    acc_ea      = 16'h0000;
    case (state_r)
      // counting starts at the first edge after release
      ST_INIT: begin
        if (cnt_r == INIT_CYCLES - 3'h1) begin
          state_nxt   = ST_VEC_REQ;
          vec_irq_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      // mask set, then vector low byte read
      ST_VEC_REQ: begin
        p_nxt[FLAG_I] = 1'b1;
        bus_a_nxt     = vec_irq_r ? IRQ_VEC_LO : RESET_VEC_LO;
        state_nxt     = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_nxt[7:0] = rdata;
        bus_a_nxt   = vec_irq_r ? IRQ_VEC_HI : RESET_VEC_HI;
        state_nxt   = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        pc_nxt[15:8] = rdata;
        state_nxt    = ST_FETCH;
      end
      // boundary check on a low, unmasked request
      ST_FETCH: begin
        if (!irq_n && !p_r[FLAG_I]) begin
          bus_a_nxt  = {STACK_PAGE, sp_r};
          bus_we_nxt = 1'b1;
          bus_wd_nxt = pc_r[15:8];
          sp_nxt     = sp_r - 8'h01;
          state_nxt  = ST_PUSH_L;
        end else begin
          bus_a_nxt = pc_r;
          pc_nxt    = pc_r + 16'h0001;
          state_nxt = ST_DECODE;
        end
      end
      ST_DECODE: begin
        ir_nxt = rdata;
        if (mode_of(rdata) == AM_IMPL || mode_of(rdata) == AM_ACC) begin
          state_nxt = ST_FETCH;
          case (rdata)
            OP_TAX: begin
              x_nxt = a_r;
              p_nxt = with_nz(p_r, a_r);
            end
            OP_INX: begin
              x_nxt = inx_val;
              p_nxt = with_nz(p_r, inx_val);
            end
            OP_ASL_A: begin
              a_nxt         = shl_val;
              p_nxt         = with_nz(p_r, shl_val);
              p_nxt[FLAG_C] = a_r[7];
            end
            OP_CLI: p_nxt[FLAG_I] = 1'b0;
            OP_SEI: p_nxt[FLAG_I] = 1'b1;
            OP_RTI: begin
              bus_a_nxt = {STACK_PAGE, sp_r + 8'h01};
              sp_nxt    = sp_r + 8'h01;
              state_nxt = ST_PULL_P;
            end
            default: ;  // no operation
          endcase
        end else begin
          bus_a_nxt = pc_r;
          pc_nxt    = pc_r + 16'h0001;
          state_nxt = ST_OP1;
        end
      end
      // second byte arrived
      ST_OP1: begin
        b2_nxt    = rdata;
        state_nxt = ST_FETCH;
        case (mode_of(ir_r))
          AM_IMM: begin
            case (ir_r)
              OP_LDX_IMM: x_nxt = rdata;
              OP_LDY_IMM: y_nxt = rdata;
              default:    a_nxt = rdata;
            endcase
            p_nxt = with_nz(p_r, rdata);
          end
          // signed offset on the already advanced counter
          AM_REL: begin
            if (bne_taken) begin
              pc_nxt = pc_r + rel_off;
            end
          end
          AM_ZP: begin
            acc_go = 1'b1;
            acc_ea = {8'h00, rdata};
          end
          // index sum stays in page zero
          AM_ZPX: begin
            acc_go = 1'b1;
            acc_ea = {8'h00, zp_sum};
          end
          // pointer low byte from page zero
          AM_INDX: begin
            bus_a_nxt = {8'h00, zp_sum};
            ptr_nxt   = zp_sum;
            state_nxt = ST_PTR_LO;
          end
          default: begin
            bus_a_nxt = pc_r;
            pc_nxt    = pc_r + 16'h0001;
            state_nxt = ST_OP2;
          end
        endcase
      end
      // third byte high, plus index where asked
      ST_OP2: begin
        state_nxt = ST_FETCH;
        if (ir_r == OP_JMP_ABS) begin
          pc_nxt = op2_base;
        end else begin
          acc_go = 1'b1;
          case (mode_of(ir_r))
            AM_ABSX: acc_ea = op2_base + {8'h00, x_r};
            AM_ABSY: acc_ea = op2_base + {8'h00, y_r};
            default: acc_ea = op2_base;
          endcase
        end
      end
      // pointer high byte, next page-zero byte
      ST_PTR_LO: begin
        b2_nxt    = rdata;
        bus_a_nxt = {8'h00, ptr_r + 8'h01};
        state_nxt = ST_PTR_HI;
      end
      ST_PTR_HI: begin
        acc_go = 1'b1;
        acc_ea = {rdata, b2_r};
      end
      // load data arrived
      ST_EXEC: begin
        a_nxt     = rdata;
        p_nxt     = with_nz(p_r, rdata);
        state_nxt = ST_FETCH;
      end
      ST_PUSH_L: begin
        bus_a_nxt  = {STACK_PAGE, sp_r};
        bus_we_nxt = 1'b1;
        bus_wd_nxt = pc_r[7:0];
        sp_nxt     = sp_r - 8'h01;
        state_nxt  = ST_PUSH_P;
      end
      ST_PUSH_P: begin
        bus_a_nxt   = {STACK_PAGE, sp_r};
        bus_we_nxt  = 1'b1;
        bus_wd_nxt  = p_r;
        sp_nxt      = sp_r - 8'h01;
        vec_irq_nxt = 1'b1;
        state_nxt   = ST_VEC_REQ;
      end
      // return: status, counter low, counter high
      ST_PULL_P: begin
        p_nxt     = rdata;
        bus_a_nxt = {STACK_PAGE, sp_r + 8'h01};
        sp_nxt    = sp_r + 8'h01;
        state_nxt = ST_PULL_L;
      end
      ST_PULL_L: begin
        pc_nxt[7:0] = rdata;
        bus_a_nxt   = {STACK_PAGE, sp_r + 8'h01};
        sp_nxt      = sp_r + 8'h01;
        state_nxt   = ST_PULL_H;
      end
      ST_PULL_H: begin
        pc_nxt[15:8] = rdata;
        state_nxt    = ST_FETCH;
      end
      default: state_nxt = ST_INIT;  // recover from an illegal code
    endcase
    // operand access: a store ends the instruction, a load waits for data
    if (acc_go) begin
      bus_a_nxt = acc_ea;
      if (is_store(ir_r)) begin
        bus_we_nxt = 1'b1;
        bus_wd_nxt = a_r;
        state_nxt  = ST_FETCH;
      end else begin
        state_nxt = ST_EXEC;
      end
    end
  end

  // sequencer and architectural registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_INIT;
      cnt_r     <= 3'h0;
      a_r       <= 8'h00;
      x_r       <= 8'h00;
      y_r       <= 8'h00;
      sp_r      <= SP_RST;
      pc_r      <= 16'h0000;
      p_r       <= STATUS_RST;
      ir_r      <= 8'h00;
      b2_r      <= 8'h00;
      ptr_r     <= 8'h00;
      vec_irq_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      a_r       <= a_nxt;
      x_r       <= x_nxt;
      y_r       <= y_nxt;
      sp_r      <= sp_nxt;
      pc_r      <= pc_nxt;
      p_r       <= p_nxt;
      ir_r      <= ir_nxt;
      b2_r      <= b2_nxt;
      ptr_r     <= ptr_nxt;
      vec_irq_r <= vec_irq_nxt;
    end
  end

  // bus pins; the core does not stall when another master owns the bus
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // strobe high and data undriven in reset
      address_lines_o  <= 16'h0000;
      address_lines_oe <= 1'b0;
      data_lines_o     <= 8'h00;
      data_lines_oe    <= 1'b0;
      write_n          <= 1'b1;
      rd_src_r         <= SRC_EXT;
    end else begin
      address_lines_o  <= bus_a_nxt;
      // address drive follows the enable input
      address_lines_oe <= address_drive_enable;
      data_lines_o     <= bus_wd_nxt;
      // drive data only on external writes
      data_lines_oe    <= bus_we_nxt && !is_internal(bus_a_nxt);
      write_n          <= !bus_we_nxt;
      rd_src_r         <= is_port(bus_a_nxt)     ? SRC_PORT :
                          is_internal(bus_a_nxt) ? SRC_RAM  : SRC_EXT;
    end
  end

  // port registers at the two lowest addresses
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_dir_r <= PORT_DIR_RST;
      port_out_r <= PORT_OUT_RST;
      port_rd_r  <= 8'h00;
    end else begin
      if (bus_we_nxt && bus_a_nxt == PORT_DIR_ADDR) begin
        port_dir_r <= bus_wd_nxt;
      end
      if (bus_we_nxt && bus_a_nxt == PORT_OUT_ADDR) begin
        port_out_r <= bus_wd_nxt;
      end
      port_rd_r <= (bus_a_nxt == PORT_DIR_ADDR) ? port_dir_r : port_view;
    end
  end

  // three stack writes of an interrupt entry
  sequence s_irq_pushes;
    !write_n [*3];
  endsequence

  a_reset_no_write: assert property (@(posedge ref_clk)
    !reset_n |-> write_n && !data_lines_oe) else $error("write during reset");
  a_init_vector: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> ##[6:8] (address_lines_o == RESET_VEC_LO && p_r[FLAG_I]))
    else $error("reset vector not fetched after start-up");
  a_rw_write_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !write_n |-> (state_r inside {ST_PUSH_L, ST_PUSH_P, ST_VEC_REQ, ST_FETCH}))
    else $error("write strobe outside a write");
  a_ram_hiz: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (address_lines_o[15:9] == 7'h00) |-> !data_lines_oe) else $error("data driven on ram access");
  a_addr_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(reset_n) |-> address_lines_oe == $past(address_drive_enable))
    else $error("address drive mismatch");
  a_irq_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_FETCH && !irq_n && !p_r[FLAG_I]) |=>
    s_irq_pushes ##1 (address_lines_o == IRQ_VEC_LO && p_r[FLAG_I]))
    else $error("interrupt entry sequence wrong");
  a_irq_boundary: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_PUSH_L) |-> $past(state_r) == ST_FETCH) else $error("entry mid-instruction");
  a_zp_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_OP1 && mode_of(ir_r) inside {AM_ZP, AM_ZPX}) |=>
    address_lines_o[15:8] == 8'h00) else $error("zero page left page zero");
  a_abs_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_OP2 && mode_of(ir_r) == AM_ABSX) |=>
    address_lines_o == $past(op2_base) + {8'h00, $past(x_r)}) else $error("bad indexed address");
  a_branch_rel: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_OP1 && ir_r == OP_BNE && !p_r[FLAG_Z]) |=>
    pc_r == $past(pc_r) + $past(rel_off)) else $error("branch target wrong");

endmodule : cbr_core

// ==== verif/cbr_mem_model.sv ====
// external memory partner: 64k bytes, combinational read, write on the edge.
// assumes the core holds address, data and strobe for one whole cycle.
module cbr_mem_model (
  // clock
  input  wire logic        ref_clk,
  // bus from the core
  input  wire logic [15:0] addr,
  input  wire logic        addr_oe,
  input  wire logic [7:0]  wdata,
  input  wire logic        wdata_oe,
  input  wire logic        write_n,
  // read data back
  output logic      [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];  // byte store, loaded by the bench
  // released address: answer the inverse, never a stale byte
  assign rdata = addr_oe ? mem[addr] : ~mem[addr];
  // latch only writes the core really drives out
  // plain always: the bench also loads this array by hierarchy
  always @(posedge ref_clk) begin
    if (addr_oe && !write_n && wdata_oe) begin
      mem[addr] <= wdata;
    end
  end
endmodule : cbr_mem_model

// ==== verif/cbr_core_test.sv ====
// bench for the core: start-up, addressing, port, interrupt, address release.
// assumes the memory model answers every address at or above 0200.
module cbr_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cbr_pkg::*;
  logic        ref_clk, reset_n, address_drive_enable, irq_n;
  logic        address_lines_oe, data_lines_oe, write_n;
  logic [15:0] address_lines_o;
  logic [7:0]  data_lines_i, data_lines_o, pins_o, pins_oe, r, r2, x;
  logic [7:0]  prog [$];
  logic [31:0] seed;
  int          err_total, checked, n, pushes;

  cbr_core u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .address_drive_enable(address_drive_enable), .address_lines_o(address_lines_o),
    .address_lines_oe(address_lines_oe), .data_lines_i(data_lines_i),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .write_n(write_n),
    .irq_n(irq_n), .peripheral_port_pins_i(~r2), .peripheral_port_pins_o(pins_o),
    .peripheral_port_pins_oe(pins_oe));
  cbr_mem_model u_mem (.ref_clk(ref_clk), .addr(address_lines_o),
    .addr_oe(address_lines_oe), .wdata(data_lines_o), .wdata_oe(data_lines_oe),
    .write_n(write_n), .rdata(data_lines_i));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // port read: latch bit where output, pin bit where input
  function automatic logic [7:0] port_exp(logic [7:0] dir, logic [7:0] lat, logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction : port_exp

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // bounded wait for an address; running out ends the run
  task automatic wait_addr(logic [15:0] a, int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (address_lines_o !== a && cnt < lim);
    if (address_lines_o !== a) begin
      chk("address wait", a, address_lines_o);
      stop_test();
    end
  endtask : wait_addr

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // every cycle: stack pushes counted, bus write rules watched
  always @(posedge ref_clk) begin
    #1;
    if (!write_n && address_lines_o[15:8] == STACK_PAGE) pushes++;
    chk("write_n in reset", 16'h1, 16'(reset_n | write_n));
    chk("data oe internal", 16'h0, 16'(data_lines_oe & (address_lines_o < 16'h0200)));
  end

  initial begin
    reset_n = 1'b1;
    address_drive_enable = 1'b1;
    irq_n = 1'b1;
    r2 = 8'h00;
    seed = 32'h44a8671f;
    // a sure falling edge, so the reset branch runs before the first clock
    #1 reset_n = 1'b0;
    for (int it = 0; it < 2; it++) begin
      seed = lfsr(lfsr(seed));
      {x, r2, r} = {8'hf1 + seed[18:16], seed[15:0]};
      // store via page one, read back zp,x wrapping, then abs,x and abs;
      // direction r mixes port inputs and outputs, the port read lands at 0401
      prog = '{8'ha9, r, 8'h8d, 8'hf0, 8'h01, 8'ha2, x, 8'hb5, 8'hf0 - x, 8'h9d, 8'h00,
               8'h03, 8'h8d, 8'h00, 8'h04, 8'h85, 8'h00, 8'ha9, r2, 8'h85, 8'h01, 8'ha5,
               8'h01, 8'h8d, 8'h01, 8'h04, 8'h58, 8'h4c, 8'h1b, 8'h02, 8'h00, 8'h02,
               8'h80, 8'h02};
      foreach (prog[i]) u_mem.mem[(i < 30) ? 16'h0200 + i : 16'hffde + i] = prog[i];
      // handler is a bare return
      u_mem.mem[16'h0280] = 8'h40;
      u_mem.mem[16'h0300 + x] = ~r;
      u_mem.mem[16'h0400] = ~r;
      u_mem.mem[16'h0401] = r ^ r2;
      @(negedge ref_clk);
      reset_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      wait_addr(RESET_VEC_LO, 20, n);
      chk("start-up cycles", 16'd7, 16'(n));
      wait_addr(RESET_VEC_HI, 1, n);
      wait_addr(16'h021b, 300, n);
      chk("abs,x store", {8'h00, r}, {8'h00, u_mem.mem[16'h0300 + x]});
      chk("abs store", {8'h00, r}, {8'h00, u_mem.mem[16'h0400]});
      chk("port latch", {8'h00, r2}, {8'h00, pins_o});
      chk("port direction", {8'h00, r}, {8'h00, pins_oe});
      chk("port read", {8'h00, port_exp(r, r2, ~r2)}, {8'h00, u_mem.mem[16'h0401]});
      pushes = 0;
      @(negedge ref_clk);
      irq_n = 1'b0;
      wait_addr(IRQ_VEC_LO, 20, n);
      chk("stack pushes", 16'd3, 16'(pushes));
      wait_addr(IRQ_VEC_HI, 1, n);
      wait_addr(16'h0280, 4, n);
      // handler returns at once; the request still low must be taken again
      wait_addr(IRQ_VEC_LO, 20, n);
      @(negedge ref_clk);
      irq_n = 1'b1;
      wait_addr(16'h0280, 8, n);
    end
    @(negedge ref_clk);
    address_drive_enable = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("address oe off", 16'h0, 16'(address_lines_oe));
    @(negedge ref_clk);
    address_drive_enable = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("address oe on", 16'h1, 16'(address_lines_oe));
    stop_test();
  end
endmodule : cbr_core_test
